// ===== rtl/rxsb_defs.svh
`ifndef RXSB_DEFS_SVH
`define RXSB_DEFS_SVH

// register indices; byte address is four times the index
`define RXSB_IDX_CFG        8'hD2
`define RXSB_IDX_STATUS     8'hD3
`define RXSB_IDX_CTRL       8'hD4
`define RXSB_IDX_DATA       8'hD5
`define RXSB_IDX_FLAGS0     8'hD6
`define RXSB_IDX_FLAGS1     8'hD7
`define RXSB_IDX_FLAGS2     8'hD8
`define RXSB_IDX_FLAGS3     8'hD9
`define RXSB_IDX_MASK       8'hDA

// configuration fields
`define RXSB_CFG_FREEZE     3
`define RXSB_CFG_DEBOUNCE   2
`define RXSB_CFG_IRQEN      1
// status and control fields
`define RXSB_STAT_BUSY      0
`define RXSB_CTRL_DIR       7
// extract-enable bit of an indirect byte
`define RXSB_IND_EN         4

// reset values
`define RXSB_CFG_RST        3'h0
`define RXSB_CTRL_RST       8'h00
`define RXSB_DATA_RST       8'h00
`define RXSB_FLAGS_RST      30'h00000000
`define RXSB_MASK_RST       30'h3FFFFFFF

// timeslots that carry no signaling
`define RXSB_TS_FRAME       5'h00
`define RXSB_TS_MFRAME      5'h10

`endif

// ===== rtl/rxsb_pkg.sv
package rxsb_pkg;

  // one received signaling codeword
  typedef struct packed {
    logic [4:0] ts;
    logic [3:0] abcd;
  } rxsb_sig_s;

  // per-timeslot storage word
  typedef struct packed {
    logic       en;
    logic [3:0] prev;
    logic [3:0] abcd;
  } rxsb_slot_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SIG,
    ST_HOST
  } rxsb_state_e;

endpackage

// ===== rtl/rxsb_ram.sv
`timescale 1ns/1ps

module rxsb_ram
  import rxsb_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [4:0] addr,
  input  wire logic       we,
  input  wire rxsb_slot_s wdata,
  output rxsb_slot_s      rdata
);

  rxsb_slot_s mem [32];

  // reset clears every slot so stored nibbles and enables start at zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 32; i++) begin
        mem[i] <= '0;
      end
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
      if (we) begin
        mem[addr] <= wdata;
      end
    end
  end

endmodule

// ===== rtl/rxsb_top.sv
`timescale 1ns/1ps
`include "rxsb_defs.svh"

module rxsb_top
  import rxsb_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sig_valid,
  input  wire rxsb_sig_s   sig_in,
  input  wire logic        mf_sync,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture

  logic       ap_valid;
  logic       ap_write;
  logic [7:0] ap_idx;
  logic       ap_low;
  logic       rd_wait;

  wire addr_ok = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_idx   <= 8'h00;
      ap_low   <= 1'b0;
    end else if (hready) begin
      ap_valid <= addr_ok;
      ap_write <= hwrite;
      ap_idx   <= haddr[9:2];
      ap_low   <= (haddr[31:10] == 22'h000000);
    end
  end

  // reads take one wait state so that hrdata sees writes of the previous transfer
  wire rd_start = ap_valid & ~ap_write & ~rd_wait;
  wire wr_en    = ap_valid & ap_write & ap_low;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= rd_start;
    end
  end

  assign hreadyout = ~rd_start;
  assign hresp     = 1'b0;

  wire sel_cfg   = wr_en & (ap_idx == `RXSB_IDX_CFG);
  wire sel_ctrl  = wr_en & (ap_idx == `RXSB_IDX_CTRL);
  wire sel_data  = wr_en & (ap_idx == `RXSB_IDX_DATA);
  wire sel_f0    = wr_en & (ap_idx == `RXSB_IDX_FLAGS0);
  wire sel_f1    = wr_en & (ap_idx == `RXSB_IDX_FLAGS1);
  wire sel_f2    = wr_en & (ap_idx == `RXSB_IDX_FLAGS2);
  wire sel_f3    = wr_en & (ap_idx == `RXSB_IDX_FLAGS3);
  wire sel_mask  = wr_en & (ap_idx == `RXSB_IDX_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // direct registers

  logic [2:0]  cfg;
  logic [7:0]  ctrl;
  logic [7:0]  data;
  logic        busy;
  logic [29:0] flags;
  logic [29:0] mask;

  wire freeze               = cfg[`RXSB_CFG_FREEZE - 1];
  wire debounce_enable      = cfg[`RXSB_CFG_DEBOUNCE - 1];
  wire signaling_irq_enable = cfg[`RXSB_CFG_IRQEN - 1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg  <= `RXSB_CFG_RST;
      mask <= `RXSB_MASK_RST;
    end else begin
      if (sel_cfg) begin
        cfg <= hwdata[`RXSB_CFG_FREEZE:`RXSB_CFG_IRQEN];
      end
      if (sel_mask) begin
        mask <= hwdata[29:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // signaling capture

  rxsb_sig_s sig_hold;
  logic      sig_pend;
  rxsb_sig_s cur_sig;
  logic [4:0] cur_ts;

  // codewords of slot 0 and 16 carry no signaling; out of sync nothing is taken
  wire sig_take_in = sig_valid & mf_sync & (sig_in.ts != `RXSB_TS_FRAME)
                     & (sig_in.ts != `RXSB_TS_MFRAME);

  rxsb_state_e state;
  rxsb_state_e next_state;

  wire take_sig  = (state == ST_IDLE) & sig_pend;
  wire take_host = (state == ST_IDLE) & ~sig_pend & busy;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sig_hold <= '0;
      sig_pend <= 1'b0;
    end else if (sig_take_in) begin
      sig_hold <= sig_in;
      sig_pend <= 1'b1;
    end else if (take_sig) begin
      sig_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot memory and arbitration

  rxsb_slot_s slot;
  rxsb_slot_s next_slot;
  logic [4:0] mem_addr;
  logic       mem_we;

  // host address fits a slot: 01h-0Fh or 11h-1Fh
  wire host_ok = (ctrl[6:5] == 2'b00) & (ctrl[4:0] != `RXSB_TS_FRAME)
                 & (ctrl[4:0] != `RXSB_TS_MFRAME);
  wire host_rd = ctrl[`RXSB_CTRL_DIR];

  assign mem_addr = (state != ST_IDLE) ? cur_ts : (sig_pend ? sig_hold.ts : ctrl[4:0]);

  rxsb_ram u_ram (
    .hclk    (hclk),
    .hresetn (hresetn),
    .addr    (mem_addr),
    .we      (mem_we),
    .wdata   (next_slot),
    .rdata   (slot)
  );

  // freeze blocks both the stored and the de-bounce history
  wire upd_ok  = slot.en & ~freeze;
  wire cand_ok = ~debounce_enable | (cur_sig.abcd == slot.prev);
  wire sig_upd = upd_ok & cand_ok;
  wire cos     = (state == ST_SIG) & sig_upd & (cur_sig.abcd != slot.abcd);

  always_comb begin
    next_slot = slot;
    mem_we    = 1'b0;
    case (state)
      ST_SIG: begin
        mem_we = 1'b1;
        if (upd_ok) begin
          next_slot.prev = cur_sig.abcd;
        end
        if (sig_upd) begin
          next_slot.abcd = cur_sig.abcd;
        end
      end
      ST_HOST: begin
        // signaling bits are read-only; only the enable is written
        mem_we       = ~host_rd & host_ok;
        next_slot.en = data[`RXSB_IND_EN];
      end
      default: begin
        mem_we = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take_sig) begin
          next_state = ST_SIG;
        end else if (take_host) begin
          next_state = ST_HOST;
        end
      end
      ST_SIG:  next_state = ST_IDLE;
      ST_HOST: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state   <= ST_IDLE;
      cur_sig <= '0;
      cur_ts  <= 5'h00;
    end else begin
      state <= next_state;
      if (take_sig) begin
        cur_sig <= sig_hold;
        cur_ts  <= sig_hold.ts;
      end else if (take_host) begin
        cur_ts <= ctrl[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indirect access registers

  wire host_done = (state == ST_HOST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `RXSB_CTRL_RST;
      busy <= 1'b0;
    end else if (sel_ctrl & ~busy) begin
      // a new operation while busy is dropped to keep the pending one intact
      ctrl <= hwdata[7:0];
      busy <= 1'b1;
    end else if (host_done) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data <= `RXSB_DATA_RST;
    end else if (host_done & host_rd) begin
      data <= host_ok ? {3'h0, slot.en, slot.abcd} : 8'h00;
    end else if (sel_data) begin
      data <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // change-of-state flags and interrupt

  // timeslot 16 is skipped, so slots above it sit one bit lower
  wire [4:0]  cos_bit  = cur_ts - (cur_ts[4] ? 5'h02 : 5'h01);
  wire [29:0] set_mask = {29'h0, cos} << cos_bit;
  wire [29:0] clr_mask = {sel_f3 ? hwdata[5:0] : 6'h00,
                          sel_f2 ? hwdata[7:0] : 8'h00,
                          sel_f1 ? hwdata[7:0] : 8'h00,
                          sel_f0 ? hwdata[7:0] : 8'h00};
  // a change in the clearing cycle is kept
  wire [29:0] next_flags = (flags & ~clr_mask) | set_mask;
  wire        next_irq   = signaling_irq_enable & |(flags & mask);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= `RXSB_FLAGS_RST;
      irq   <= 1'b0;
    end else begin
      flags <= next_flags;
      irq   <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  wire rd_hit = ap_low;
  wire [31:0] rd_mux =
      !rd_hit                          ? 32'h00000000 :
      (ap_idx == `RXSB_IDX_CFG)        ? {28'h0, cfg, 1'b0} :
      (ap_idx == `RXSB_IDX_STATUS)     ? {31'h0, busy} :
      (ap_idx == `RXSB_IDX_CTRL)       ? {24'h0, ctrl} :
      (ap_idx == `RXSB_IDX_DATA)       ? {24'h0, data} :
      (ap_idx == `RXSB_IDX_FLAGS0)     ? {24'h0, flags[7:0]} :
      (ap_idx == `RXSB_IDX_FLAGS1)     ? {24'h0, flags[15:8]} :
      (ap_idx == `RXSB_IDX_FLAGS2)     ? {24'h0, flags[23:16]} :
      (ap_idx == `RXSB_IDX_FLAGS3)     ? {26'h0, flags[29:24]} :
      (ap_idx == `RXSB_IDX_MASK)       ? {2'h0, mask} :
                                         32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_start) begin
      hrdata <= rd_mux;
    end
  end

endmodule

// ===== test/rxsb_chk.sv
`timescale 1ns/1ps
`include "rxsb_defs.svh"

module rxsb_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sig_valid,
  input wire logic        mf_sync,
  input wire logic        irq
);
  logic       wa;
  logic       wc;
  logic [3:0] cfg;
  logic [2:0] wage;
  logic [2:0] sage;
  logic [2:0] fage;
  wire        take = hsel && htrans[1] && hready;
  wire        to_cfg = haddr[9:2] == `RXSB_IDX_CFG && haddr[31:10] == 22'h0;
  ////////////////////////////////////////////////////////////////////////
  // ages saturate at 7 so a long quiet spell never wraps into a cause
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wa, wc, cfg, fage} <= '0;
      {wage, sage}        <= '1;
    end else begin
      wa   <= take && hwrite;
      wc   <= take && hwrite && to_cfg;
      cfg  <= wc ? hwdata[3:0] : cfg;
      wage <= wa ? 3'h0 : wage + {2'h0, wage != 3'h7};
      sage <= (sig_valid && mf_sync) ? 3'h0 : sage + {2'h0, sage != 3'h7};
      fage <= !cfg[3] ? 3'h0 : fage + {2'h0, fage != 3'h7};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_take;
    take && !hwrite;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_read_wait: assert property (s_rd_take |=> s_one_wait) else $error("read wait not one cycle");
  a_wait_cause: assert property (!hreadyout |-> $past(take && !hwrite)) else $error("stray wait state");
  // the mask register is 30 bits wide; every other register fits in a byte
  a_read_upper: assert property (s_rd_take |=> ##1 (hrdata[31:8] == 24'h0 ||
    ($past(haddr[9:2], 2) == `RXSB_IDX_MASK && hrdata[31:30] == 2'h0))) else $error("upper read bits set");
  a_irq_gate: assert property (!cfg[1] && $past(!cfg[1]) |-> !irq) else $error("irq while disabled");
  a_irq_cause: assert property ($rose(irq) |-> wage <= 3'h3 || sage <= 3'h6) else $error("irq no cause");
  a_frz_quiet: assert property ($rose(irq) && fage >= 3'h6 |-> wage <= 3'h3) else $error("irq frozen");
  a_irq_clear: assert property ($fell(irq) |-> wage <= 3'h3) else $error("irq fell without write");
endmodule

bind rxsb_top rxsb_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .sig_valid(sig_valid), .mf_sync(mf_sync), .irq(irq));

// ===== test/rxsb_framer.sv
`timescale 1ns/1ps

module rxsb_framer
  import rxsb_pkg::*;
(
  input  wire logic      hclk,
  input  wire logic      hresetn,
  input  wire logic      send,
  input  wire rxsb_sig_s word,
  input  wire logic      sync,
  output logic           sig_valid,
  output rxsb_sig_s      sig_in,
  output logic           mf_sync
);
  // between codewords the stream inverts every cycle, so a stale word never stays on it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sig_valid <= 1'b0;
      sig_in    <= '0;
      mf_sync   <= 1'b0;
    end else begin
      sig_valid <= send;
      sig_in    <= send ? word : ~sig_in;
      mf_sync   <= sync;
    end
  end
endmodule

// ===== test/rxsb_top_tb.sv
`timescale 1ns/1ps
`include "rxsb_defs.svh"

module rxsb_top_tb import rxsb_pkg::*; ();
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, send = 1'b0, sync = 1'b1, dpc = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, fl = '0, msk = 32'h3FFFFFFF, x, exp_q[$];
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, cf = 3'h0;
  logic [3:0]  ab[32], lst[32];
  logic        en[32];
  rxsb_sig_s   word = '0;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, irq, sig_valid, mf_sync;
  wire rxsb_sig_s sig_in;
  int          fail_count = 0, n_compared = 0;
  always #2 hclk = ~hclk;
  rxsb_top u_rxsb_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sig_valid(sig_valid), .sig_in(sig_in), .mf_sync(mf_sync), .irq(irq));
  rxsb_framer u_rxsb_framer (.hclk(hclk), .hresetn(hresetn), .send(send), .word(word), .sync(sync),
    .sig_valid(sig_valid), .sig_in(sig_in), .mf_sync(mf_sync));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // results are taken mid-cycle, so they never race the edge that moves them
  always @(negedge hclk) if (dpc && hreadyout === 1'b1) chk("hrdata", exp_q.pop_front(), hrdata);
  task automatic hs(output logic [31:0] d);
    int  n;
    logic r;
    n = 0;
    do begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
      n++;
      if (n > 40) begin
        fail_count++;
        conclude();
      end
    end while (r !== 1'b1);
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] v, input logic c, output logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hs(d);
    htrans <= 2'h0;
    hwdata <= v;
    dpc    <= c;
    hs(d);
    dpc    <= 1'b0;
  endtask
  function automatic logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'h0};
  endfunction
  task automatic wr(input logic [7:0] i, input logic [31:0] v);
    logic [31:0] d;
    xfer(1'b1, ad(i), v, 1'b0, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    exp_q.push_back(e);
    xfer(1'b0, a, '0, 1'b1, d);
  endtask
  task automatic idle();
    logic [31:0] d;
    int          n;
    n = 0;
    do begin
      xfer(1'b0, ad(`RXSB_IDX_STATUS), '0, 1'b0, d);
      n++;
    end while (d[0] !== 1'b0 && n < 20);
    if (d[0] !== 1'b0) begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic iw(input logic [4:0] t, input logic [7:0] v);
    wr(`RXSB_IDX_DATA, {24'h0, v});
    wr(`RXSB_IDX_CTRL, {27'h0, t});
    idle();
    if (t != 5'h0 && t != 5'h10) en[t] = v[4];
  endtask
  task automatic ir(input logic [6:0] t);
    wr(`RXSB_IDX_CTRL, {24'h0, 1'b1, t});
    rd(ad(`RXSB_IDX_STATUS), 32'h1);
    idle();
    rd(ad(`RXSB_IDX_DATA), (t[6:5] == 2'h0 && t[3:0] != 4'h0) ? {27'h0, en[t[4:0]], ab[t[4:0]]} : 32'h0);
  endtask
  task automatic snd(input logic [4:0] t, input logic [3:0] v, input logic s);
    logic ok;
    word <= {t, v};
    sync <= s;
    send <= 1'b1;
    @(posedge hclk);
    send <= 1'b0;
    repeat (8) @(posedge hclk);
    ok = s && en[t] && !cf[2] && t != 5'h0 && t != 5'h10;
    if (ok && (!cf[1] || v == lst[t])) begin
      if (v != ab[t]) fl[t - (t < 5'h10 ? 5'h1 : 5'h2)] = 1'b1;
      ab[t] = v;
    end
    if (ok) lst[t] = v;
  endtask
  task automatic irqchk();
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("irq", {31'h0, cf[0] & |(fl & msk)}, {31'h0, irq});
    @(posedge hclk);
  endtask
  task automatic chk_all();
    for (int k = 0; k < 4; k++) rd(ad(`RXSB_IDX_FLAGS0 + 8'(k)), {24'h0, fl[8*k +: 8]});
    for (int t = 0; t < 32; t++) ir(7'(t));
    irqchk();
  endtask
  task automatic cfgw(input logic [2:0] c);
    cf = c;
    wr(`RXSB_IDX_CFG, {28'h0, c, 1'b0});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h9CDA3111));
    for (int t = 0; t < 32; t++) {en[t], ab[t], lst[t]} = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ad(`RXSB_IDX_CFG), 32'h0);
    rd(ad(`RXSB_IDX_CTRL), 32'h0);
    rd(ad(`RXSB_IDX_DATA), 32'h0);
    rd(ad(`RXSB_IDX_MASK), 32'h3FFFFFFF);
    wr(8'h00, 32'hFFFFFFFF);
    rd(32'h00001348, 32'h0);
    chk_all();
    // slot 2 stays disabled so refused codewords are seen
    for (int t = 1; t < 32; t++) iw(5'(t), t == 2 ? 8'($urandom) & 8'hEF : 8'($urandom) | 8'h10);
    iw(5'h10, 8'hFF);
    ir(7'h20);
    ir(7'h7F);
    cfgw(3'h0);
    for (int i = 0; i < 40; i++) snd(5'($urandom), 4'($urandom), i % 7 != 3);
    chk_all();
    cfgw(3'h1);
    irqchk();
    wr(`RXSB_IDX_MASK, 32'h0);
    msk = 32'h0;
    irqchk();
    msk = {2'h0, 30'($urandom)};
    wr(`RXSB_IDX_MASK, msk);
    irqchk();
    msk = 32'h3FFFFFFF;
    wr(`RXSB_IDX_MASK, msk);
    x = $urandom;
    for (int k = 0; k < 4; k++) wr(`RXSB_IDX_FLAGS0 + 8'(k), x);
    for (int k = 0; k < 4; k++) fl[8*k +: 8] = fl[8*k +: 8] & ~x[7:0];
    chk_all();
    cfgw(3'h3);
    for (int i = 0; i < 24; i++) snd(5'($urandom % 4) + 5'h1, 4'($urandom) & 4'h3, 1'b1);
    chk_all();
    cfgw(3'h5);
    for (int i = 0; i < 10; i++) snd(5'($urandom), 4'($urandom), 1'b1);
    wr(`RXSB_IDX_MASK, 32'h0);
    msk = 32'h0;
    irqchk();
    msk = 32'h3FFFFFFF;
    wr(`RXSB_IDX_MASK, msk);
    chk_all();
    cfgw(3'h1);
    for (int i = 0; i < 10; i++) snd(5'($urandom), 4'($urandom), 1'b1);
    chk_all();
    conclude();
  end
endmodule
